// ===== optical_link_fault_handler.sv
// Fault detection and reaction for the optical communication module.
// Assumes the link receivers deliver words with their CRC result already computed,
// and that link status pins come from outside the core clock domain.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Failed CRC data is tagged invalid
// - Error state latched until power off or worse
// - Command loss stops fiber and serial output
// - Failure code driven to indication board unit
// - Remote link loss marks its data invalid
// - Lost remote link words forwarded as zero
// - Internal failure stops the heartbeat toggling
// - Bad parameters halt fiber and serial transfer
// - Backplane link: four lines, full duplex (not built in this block)
// - Point-to-point links carry no slot address
module optical_link_fault_handler #(
    parameter int NREM = olfh_pkg::NUM_REMOTE,
    parameter int TIMEOUT_CYC = olfh_pkg::LINK_TIMEOUT_CYC,
    parameter int HB_CYC = olfh_pkg::HEARTBEAT_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire olfh_pkg::olfh_word_t cmdWord,
    input wire logic cmdValid,
    input wire olfh_pkg::olfh_word_t remWord,
    input wire logic remValid,
    input wire logic paramBadPin,
    input wire logic internalFailPin,
    output olfh_pkg::olfh_fwd_t toLogic,
    input wire logic toLogicReady,
    output logic fiberTxEnable,
    output logic serialTxEnable,
    output logic rxEnable,
    output logic heartbeat,
    output olfh_pkg::olfh_fcode_t failCode,
    output logic [NREM-1:0] remoteLost,
    output logic cmdLost,
    output logic crcErrPulse,
    output logic remReady
);
    // Complete state of the handler
    typedef struct packed {
        logic [1:0] paramSync;
        logic [1:0] failSync;
        logic [olfh_pkg::CNT_W-1:0] cmdCnt;
        logic [NREM-1:0][olfh_pkg::CNT_W-1:0] remCnt;
        logic cmdLost;
        logic [NREM-1:0] remLost;
        logic [olfh_pkg::CNT_W-1:0] hbCnt;
        logic heartbeat;
        logic hbStopped;
        olfh_pkg::olfh_fcode_t code;
        logic crcErr;
        logic txOn;
        logic rxOn;
        olfh_pkg::olfh_fwd_t out;
        logic outBusy;
        logic remReady;
    } olfh_state_t;

    // Registered state and the value it takes at the next edge
    olfh_state_t st;
    olfh_state_t next_st;

    // FIFO handshake signals
    logic fifoInValid;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [olfh_pkg::DATA_W+3:0] fifoInData;
    logic [olfh_pkg::DATA_W+3:0] fifoOutData;
    logic remInRange;

    // Remote word enters the FIFO; data zeroed and invalid if bad or link lost
    // Link numbers past the last remote link are never buffered
    assign remInRange = (32'(remWord.link) < NREM);
    always_comb begin
        fifoInValid = remValid && remInRange && st.rxOn;
        if (!remWord.crcOk || st.remLost[remWord.link]) begin
            fifoInData = {olfh_pkg::DATA_W'(0), remWord.link, 1'b0};
        end else begin
            fifoInData = {remWord.data, remWord.link, 1'b1};
        end
    end

    // Buffer between the optical receivers and the logic module
    olfh_fifo #(
        .WIDTH(olfh_pkg::DATA_W + 4),
        .DEPTH(olfh_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    // Output register takes a word when empty or when the logic module accepts
    assign fifoOutReady = !st.outBusy || toLogicReady;

    // Next-state logic
    always_comb begin
        next_st = st;
        // Status pins from outside pass two flops
        next_st.paramSync = {st.paramSync[0], paramBadPin};
        next_st.failSync = {st.failSync[0], internalFailPin};
        next_st.crcErr = 1'b0;
        next_st.remReady = fifoInReady;

        // Command link timeout; restarts on each good command packet
        // Only a good closing word proves that the command link is alive
        if (cmdValid && cmdWord.crcOk && cmdWord.last) begin
            next_st.cmdCnt = olfh_pkg::CNT_RESET;
        end else if (st.cmdCnt != olfh_pkg::CNT_W'(TIMEOUT_CYC)) begin
            next_st.cmdCnt = st.cmdCnt + 1'b1;
        end else begin
            next_st.cmdLost = 1'b1;
        end

        // Per remote link timeout counters
        for (int i = 0; i < NREM; i++) begin
            if (remValid && remWord.crcOk && remWord.last && 32'(remWord.link) == i) begin
                next_st.remCnt[i] = olfh_pkg::CNT_RESET;
            end else if (st.remCnt[i] != olfh_pkg::CNT_W'(TIMEOUT_CYC)) begin
                next_st.remCnt[i] = st.remCnt[i] + 1'b1;
            end else begin
                next_st.remLost[i] = 1'b1;
            end
        end

        // Any failed check is an internal high-level failure
        // A bad check on either link freezes the heartbeat for good
        if ((cmdValid && !cmdWord.crcOk) || (remValid && !remWord.crcOk)) begin
            next_st.crcErr = 1'b1;
            next_st.hbStopped = 1'b1;
        end
        if (st.failSync[1]) begin
            next_st.hbStopped = 1'b1;
        end

        // Transmit and receive gating
        // Command loss stops transmit only; reception stays open
        if (st.paramSync[1]) begin
            next_st.txOn = 1'b0;
            next_st.rxOn = 1'b0;
        end
        if (st.cmdLost) begin
            next_st.txOn = 1'b0;
        end

        // Latched failure code; only a more severe code replaces it
        // Tested most severe first, so one cycle never raises a weaker code
        if (st.hbStopped && st.code < olfh_pkg::OLFH_FC_CRC_FAIL) begin
            next_st.code = olfh_pkg::OLFH_FC_CRC_FAIL;
        end else if (st.paramSync[1] && st.code < olfh_pkg::OLFH_FC_PARAM_BAD) begin
            next_st.code = olfh_pkg::OLFH_FC_PARAM_BAD;
        end else if (st.cmdLost && st.code < olfh_pkg::OLFH_FC_CMD_LOSS) begin
            next_st.code = olfh_pkg::OLFH_FC_CMD_LOSS;
        end else if ((|st.remLost) && st.code < olfh_pkg::OLFH_FC_REMOTE_LOSS) begin
            next_st.code = olfh_pkg::OLFH_FC_REMOTE_LOSS;
        end

        // Heartbeat toggles until a failure freezes it
        // A frozen heartbeat is what makes the watchdog cut power
        if (!st.hbStopped) begin
            if (st.hbCnt == olfh_pkg::CNT_W'(HB_CYC - 1)) begin
                next_st.hbCnt = olfh_pkg::CNT_RESET;
                next_st.heartbeat = !st.heartbeat;
            end else begin
                next_st.hbCnt = st.hbCnt + 1'b1;
            end
        end

        // Output register toward the logic module; no slot address is carried
        if (fifoOutReady) begin
            next_st.outBusy = fifoOutValid;
            next_st.out.data = fifoOutData[olfh_pkg::DATA_W+3:4];
            next_st.out.link = fifoOutData[3:1];
            next_st.out.valid = fifoOutValid && fifoOutData[0];
        end
        // Zeroing looks at the loss flags of the coming cycle, so a word held
        // for a stalled reader is cleared in the same cycle that its link drops
        if (next_st.remLost[next_st.out.link]) begin
            next_st.out.data = '0;
            next_st.out.valid = 1'b0;
        end
    end

    // State register
    // Enables come up on so that both links run from the first cycle
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st <= '0;
            st.txOn <= 1'b1;
            st.rxOn <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign toLogic = st.out;
    assign fiberTxEnable = st.txOn;
    assign serialTxEnable = st.txOn;
    assign rxEnable = st.rxOn;
    assign heartbeat = st.heartbeat;
    assign failCode = st.code;
    assign remoteLost = st.remLost;
    assign cmdLost = st.cmdLost;
    assign crcErrPulse = st.crcErr;
    assign remReady = st.remReady;
    // The four-line full-duplex backplane link is outside this block
    // The logic module's safe-state trip on lost response is its own job
endmodule
`default_nettype wire

// ===== olfh_pkg.sv
// Package for the optical link fault handler: constants, types, fault codes.
// Assumes a single 200 MHz core clock and a synchronous active-low reset.
package olfh_pkg;
    localparam int CLK_MHZ = 200;            // Core clock rate in MHz
    localparam int LINK_TIMEOUT_US = 100;    // Silence allowed on a link, in us
    localparam int LINK_TIMEOUT_CYC = LINK_TIMEOUT_US * CLK_MHZ; // Cycles of silence
    localparam int HEARTBEAT_US = 10;        // Half period of heartbeat, in us
    localparam int HEARTBEAT_CYC = HEARTBEAT_US * CLK_MHZ;        // Cycles per toggle
    localparam int DATA_W = 32;              // Data word width
    localparam int FIFO_DEPTH = 32;          // Words buffered toward the logic module
    localparam int NUM_REMOTE = 5;           // Optical links to remote chassis
    localparam int CNT_W = 24;               // Width of timeout counters
    localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000; // Counter reset value

    // Failure codes shown on the indication board unit, higher is more severe
    typedef enum logic [3:0] {
        OLFH_FC_NONE = 4'h0,
        OLFH_FC_REMOTE_LOSS = 4'h1,
        OLFH_FC_CMD_LOSS = 4'h2,
        OLFH_FC_PARAM_BAD = 4'h3,
        OLFH_FC_CRC_FAIL = 4'h4
    } olfh_fcode_t;

    // One received word with its source and check result
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [2:0] link;
        logic crcOk;
        logic last;
    } olfh_word_t;

    // Word forwarded toward the logic module
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [2:0] link;
        logic valid;
    } olfh_fwd_t;
endpackage

// ===== olfh_fifo.sv
// Synchronous FIFO of flip-flops with valid and ready on both sides.
// Assumes one clock shared with the writer and the reader.
`timescale 1ns/1ps
`default_nettype none
module olfh_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    // Complete state of the FIFO
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } olfh_fifo_t;

    olfh_fifo_t st;
    olfh_fifo_t next_st;
    logic push;
    logic pop;

    // Handshakes on both sides
    assign inReady = (st.count != (AW+1)'(DEPTH));
    assign outValid = (st.count != '0);
    assign outData = st.mem[st.rd];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Next-state logic
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = inData;
            next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// ===== olfh_checker.sv
// Port checker for the optical link fault handler.
// Bound onto the top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module olfh_checker #(
    parameter int NREM = olfh_pkg::NUM_REMOTE,
    parameter int TIMEOUT_CYC = olfh_pkg::LINK_TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire olfh_pkg::olfh_word_t cmdWord,
    input wire logic cmdValid,
    input wire olfh_pkg::olfh_word_t remWord,
    input wire logic remValid,
    input wire logic paramBadPin,
    input wire olfh_pkg::olfh_fwd_t toLogic,
    input wire logic fiberTxEnable,
    input wire logic serialTxEnable,
    input wire logic rxEnable,
    input wire logic heartbeat,
    input wire olfh_pkg::olfh_fcode_t failCode,
    input wire logic [NREM-1:0] remoteLost,
    input wire logic cmdLost,
    input wire logic crcErrPulse,
    input wire logic remReady
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [15:0] quiet; // Cycles since the last good command packet
    // Silence counter, cleared by a good closing command word
    always_ff @(posedge core_clk) begin
        if (!nrst || (cmdValid && cmdWord.crcOk && cmdWord.last)) begin
            quiet <= 16'h0000;
        end else if (quiet != 16'hffff) begin
            quiet <= quiet + 16'h0001;
        end
    end
    property p_crc;
        remValid && rxEnable && remReady && !remWord.crcOk && remWord.link < NREM |=> crcErrPulse;
    endproperty
    a_crc: assert property (p_crc) else $error("crc pulse missing");
    property p_hold; failCode != olfh_pkg::OLFH_FC_NONE |=> failCode >= $past(failCode); endproperty
    a_hold: assert property (p_hold) else $error("fault code fell");
    property p_cmdtx; cmdLost |=> !fiberTxEnable && !serialTxEnable; endproperty
    a_cmdtx: assert property (p_cmdtx) else $error("output still on");
    property p_cmdfc; cmdLost |=> failCode >= olfh_pkg::OLFH_FC_CMD_LOSS; endproperty
    a_cmdfc: assert property (p_cmdfc) else $error("no command loss code");
    property p_zero;
        !toLogic.valid && toLogic.link < NREM && remoteLost[toLogic.link] |-> toLogic.data == '0;
    endproperty
    a_zero: assert property (p_zero) else $error("lost link data not zero");
    property p_hb; crcErrPulse |-> ##2 $stable(heartbeat) [*8]; endproperty
    a_hb: assert property (p_hb) else $error("heartbeat still runs");
    property p_par; paramBadPin [*6] |-> !rxEnable && !fiberTxEnable && !serialTxEnable; endproperty
    a_par: assert property (p_par) else $error("transfer not halted");
    property p_tmo; quiet > TIMEOUT_CYC + 3 |-> cmdLost; endproperty
    a_tmo: assert property (p_tmo) else $error("command loss missed");
    // Main scenarios reached
    cover property (cmdLost);
    cover property (crcErrPulse);
    cover property (!remReady);
endmodule
bind optical_link_fault_handler olfh_checker #(.NREM(NREM), .TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (.*);
`default_nettype wire

// ===== olfh_lm_model.sv
// Logic module stand-in: sends command packets and paces the return path.
// Shares the core clock and reset with the block.
`timescale 1ns/1ps
`default_nettype none
module olfh_logic_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic talk,
    input wire logic hold,
    input wire logic badCrc,
    output olfh_pkg::olfh_word_t cmdWord,
    output logic cmdValid,
    output logic toLogicReady
);
    logic [3:0] tick; // Command pacing
    // One-word packet each 16 cycles, no slot address; data changes every cycle
    always_ff @(posedge core_clk) begin
        tick <= nrst ? tick + 4'h1 : 4'h0;
        cmdValid <= nrst && talk && tick == 4'h0;
        cmdWord <= '{nrst ? ~cmdWord.data : 32'h0, 3'h0, !badCrc, 1'b1};
        // Pacing only; the safe-state trip of the far side is not modelled
        toLogicReady <= nrst && !hold;
    end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Testbench for the optical link fault handler with a logic module model.
// Short timeout and heartbeat counts keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk = 1'b0, nrst = 1'b0, remValid = 1'b0, paramBadPin = 1'b0, h;
    logic talk = 1'b1, hold = 1'b0, cmdValid, toLogicReady, fiberTxEnable, serialTxEnable;
    logic rxEnable, heartbeat, cmdLost, crcErrPulse, remReady;
    logic internalFailPin = 1'b0, badCrc = 1'b0;
    logic [4:0] remoteLost;
    olfh_pkg::olfh_word_t remWord = '0, cmdWord;
    olfh_pkg::olfh_fwd_t toLogic;
    olfh_pkg::olfh_fcode_t failCode;
    int miscompares = 0, check_count = 0;
    initial forever #2.5 core_clk = ~core_clk;
    olfh_logic_model i_logic (
        .core_clk(core_clk),
        .nrst(nrst),
        .talk(talk),
        .hold(hold),
        .badCrc(badCrc),
        .cmdWord(cmdWord),
        .cmdValid(cmdValid),
        .toLogicReady(toLogicReady)
    );
    optical_link_fault_handler #(.TIMEOUT_CYC(60), .HB_CYC(4)) i_dut (
        .core_clk(core_clk),
        .nrst(nrst),
        .cmdWord(cmdWord),
        .cmdValid(cmdValid),
        .remWord(remWord),
        .remValid(remValid),
        .paramBadPin(paramBadPin),
        .internalFailPin(internalFailPin),
        .toLogic(toLogic),
        .toLogicReady(toLogicReady),
        .fiberTxEnable(fiberTxEnable),
        .serialTxEnable(serialTxEnable),
        .rxEnable(rxEnable),
        .heartbeat(heartbeat),
        .failCode(failCode),
        .remoteLost(remoteLost),
        .cmdLost(cmdLost),
        .crcErrPulse(crcErrPulse),
        .remReady(remReady)
    );
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Wait n edges, then sample settled outputs
    task automatic look(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic rst(input logic hd, input logic tk);
        @(posedge core_clk);
        nrst <= 1'b0;
        hold <= hd;
        talk <= tk;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
    endtask
    task automatic send(input logic [2:0] l, input logic [31:0] d, input logic ok);
        @(posedge core_clk);
        remWord <= '{d, l, ok, 1'b1};
        remValid <= 1'b1;
    endtask
    // Release the line; data keeps changing so stale words never look valid
    task automatic idle();
        @(posedge core_clk);
        remValid <= 1'b0;
        remWord.data <= ~remWord.data;
    endtask
    task automatic t_par();
        rst(1'b0, 1'b1);
        look(1);
        chk(failCode, 0);
        chk(fiberTxEnable, 1);
        @(posedge core_clk);
        paramBadPin <= 1'b1;
        look(8);
        chk(rxEnable, 0);
        chk(serialTxEnable, 0);
        chk(failCode, 3);
        @(posedge core_clk);
        paramBadPin <= 1'b0;
        look(30);
        chk(failCode, 3);
        chk(rxEnable, 0);
    endtask
    task automatic t_cmd();
        rst(1'b0, 1'b0);
        look(70);
        chk(cmdLost, 1);
        chk(fiberTxEnable, 0);
        chk(serialTxEnable, 0);
        chk(failCode, 2);
        @(posedge core_clk);
        talk <= 1'b1;
        look(40);
        chk(cmdLost, 1);
    endtask
    task automatic t_rem();
        rst(1'b1, 1'b1);
        look(70);
        chk(remoteLost[2], 1);
        chk(failCode, 1);
        send(3'h2, 32'hffffffff, 1'b1);
        idle();
        look(3);
        chk(toLogic.link, 2);
        chk(toLogic.valid, 0);
        chk(toLogic.data, 0);
        chk(remoteLost[2], 1);
    endtask
    task automatic t_crc();
        rst(1'b1, 1'b1);
        look(2);
        h = heartbeat;
        look(4);
        chk(heartbeat, !h);
        send(3'h1, 32'h5a5a5a5a, 1'b0);
        idle();
        #1;
        chk(crcErrPulse, 1);
        look(3);
        chk(crcErrPulse, 0);
        chk(toLogic.link, 1);
        chk(toLogic.valid, 0);
        chk(failCode, 4);
        h = heartbeat;
        look(12);
        chk(heartbeat, h);
    endtask
    // Fill the buffer with the reader stalled, then drain it in order
    task automatic t_fill();
        int i;
        int n;
        rst(1'b1, 1'b1);
        look(2);
        for (i = 0; i < 40 && remReady !== 1'b0; i++) send(3'h0, i, 1'b1);
        idle();
        hold <= 1'b0;
        chk(i < 40, 1);
        if (i == 40) summarize();
        n = 0;
        repeat (100) begin
            @(posedge core_clk);
            if (toLogic.valid === 1'b1 && toLogicReady === 1'b1) begin
                chk(toLogic.data, n);
                n++;
            end
        end
        chk(n >= 32, 1);
    endtask
    // Internal failure pin freezes the heartbeat and raises the top code
    task automatic t_fail();
        rst(1'b1, 1'b1);
        look(1);
        @(posedge core_clk);
        internalFailPin <= 1'b1;
        look(8);
        chk(failCode, 4);
        h = heartbeat;
        look(12);
        chk(heartbeat, h);
        @(posedge core_clk);
        internalFailPin <= 1'b0;
    endtask
    // Failed checks on command words count as a high-level failure
    task automatic t_cmdcrc();
        rst(1'b1, 1'b1);
        badCrc <= 1'b1;
        look(2);
        chk(crcErrPulse, 1);
        look(2);
        chk(failCode, 4);
        @(posedge core_clk);
        badCrc <= 1'b0;
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        t_par();
        t_cmd();
        t_rem();
        t_crc();
        t_fail();
        t_cmdcrc();
        t_fill();
        summarize();
    end
endmodule
`default_nettype wire
